// File: include/afi_enc_if.sv
// Bundle between the top and a decoder channel.
// Assumes one clock domain shared with the top.
`timescale 1ns/1ps
`include "afi_regs.svh"
interface afi_enc_if;
  logic               chanA;
  logic               chanB;
  logic               pulseDir;
  logic               enable;
  afi_pkg::afi_pos_type count;
  logic               step;
  modport dec (input chanA, input chanB, input pulseDir, input enable, output count, output step);
  modport top (output chanA, output chanB, output pulseDir, output enable, input count, input step);
endinterface : afi_enc_if

// File: include/afi_pkg.sv
// Types for the axis feedback input block.
// Assumes afi_regs.svh on the include path.
`include "afi_regs.svh"
package afi_pkg;
  typedef enum logic [1:0] {
    HS_IDLE,
    HS_ARMED,
    HS_SLEW,
    HS_STOP
  } afi_home_type;

  typedef logic [`AFI_POS_W-1:0] afi_pos_type;
endpackage : afi_pkg

// File: include/afi_regs.svh
// Constants of the axis feedback input block.
// Assumes inclusion by bare name from rtl/ and include/ files.
//
// Function
// R1: Count every A or B edge, four per cycle.
// R2: Count up to 22,000,000 states per second.
// R3: Pulse/dir: pulses on A, direction from B.
// R4: Negative legs optional.
// R5: Index records home while homing.
// R6: Aux counts on servo axes only.
// R7: Low abort stops motion, halts program.
// R8: Low reset restores power-on state; the block clears only arms, latched flags and homing states.
// R9: Lockout drops amp enables in hardware.
// R10: Forward limit blocks forward motion, calls handler.
// R11: Reverse limit blocks reverse motion, calls handler.
// R12: Limit and home polarity selectable.
// R13: Begin after homing slews, stops on home change.
// R14: Sixteen general inputs readable.
// R15: Armed latch captures position on latch signal.
// R16: Inputs 1-4 latch axes 1-4; 9-12 axes 5-8.
// R17: Capture disarms and holds until re-armed.
`ifndef AFI_REGS_SVH
`define AFI_REGS_SVH

// ****************************************************************
// Sizes
// ****************************************************************
`define AFI_AXES        8
`define AFI_POS_W       32
`define AFI_GPI_W       16
`define AFI_ADDR_W      8

// ****************************************************************
// Register offsets
// ****************************************************************
`define AFI_REG_CTRL    8'h00
`define AFI_REG_MODE    8'h04
`define AFI_REG_STATUS  8'h08
`define AFI_REG_GPI     8'h0C
`define AFI_REG_LARM    8'h10
`define AFI_REG_MOTION  8'h14
`define AFI_REG_POS     8'h20
`define AFI_REG_AUX     8'h40
`define AFI_REG_LATCH   8'h60
`define AFI_REG_HOME    8'h80
`define AFI_SEL_MSB     4
`define AFI_SEL_LSB     2
`define AFI_BANK_MSB    7
`define AFI_BANK_LSB    5

// ****************************************************************
// CTRL fields
// ****************************************************************
`define AFI_CTRL_LIMPOL  0
`define AFI_CTRL_HOMEPOL 1
`define AFI_CTRL_LATCHEN 2
`define AFI_CTRL_RESET   32'h0000_0000

// ****************************************************************
// MODE word per axis: bit0 pulse/dir, bit1 stepper, bit2 direction (1 = fwd)
// ****************************************************************
`define AFI_MODE_PD      0
`define AFI_MODE_STEP    1
`define AFI_MODE_DIR     2
`define AFI_MODE_STRIDE  3

// ****************************************************************
// MOTION command codes (write data bits 3:0 cmd, 10:8 axis)
// ****************************************************************
`define AFI_CMD_HOMING   4'h1
`define AFI_CMD_EDGE     4'h2
`define AFI_CMD_BEGIN    4'h3
`define AFI_CMD_STOP     4'h4

`endif

// File: rtl/afi_axis_inputs.sv
// Top of the axis feedback input block: pins, decoders, switches, latches, registers.
// Assumes pins are asynchronous to ref_clk; register port is on ref_clk.
//
// Chosen here: strobed register access and the placing of the registers.
`timescale 1ns/1ps
`include "afi_regs.svh"
module afi_axis_inputs (
  input  wire logic                   ref_clk,
  input  wire logic                   rstn,
  input  wire logic [`AFI_AXES-1:0]   encChanAPos,
  input  wire logic [`AFI_AXES-1:0]   encChanBPos,
  input  wire logic [`AFI_AXES-1:0]   encIndexPos,
  input  wire logic [`AFI_AXES-1:0]   encChanANeg,
  input  wire logic [`AFI_AXES-1:0]   encChanBNeg,
  input  wire logic [`AFI_AXES-1:0]   encIndexNeg,
  input  wire logic [`AFI_AXES-1:0]   diffUsed,
  input  wire logic [`AFI_AXES-1:0]   auxEncFirstPos,
  input  wire logic [`AFI_AXES-1:0]   auxEncSecondPos,
  input  wire logic [`AFI_AXES-1:0]   fwdLimit,
  input  wire logic [`AFI_AXES-1:0]   revLimit,
  input  wire logic [`AFI_AXES-1:0]   homeSwitch,
  input  wire logic                   abortN,
  input  wire logic                   resetInN,
  input  wire logic                   lockout,
  input  wire logic [`AFI_GPI_W-1:0]  genInput,
  input  wire logic [`AFI_ADDR_W-1:0] regAddr,
  input  wire logic [31:0]            regWData,
  input  wire logic                   regWrite,
  input  wire logic                   regRead,
  output logic      [31:0]            regRData,
  output logic [`AFI_AXES-1:0]        ampEnable,
  output logic [`AFI_AXES-1:0]        motionEnable,
  output logic                        programHalt,
  output logic                        softResetReq,
  output logic                        limitHandlerReq,
  output logic [`AFI_GPI_W-1:0]       genInputState
);
  localparam int N = `AFI_AXES;
  localparam int SW = 6 * N + 3 + `AFI_GPI_W;

  // ****************************************************************
  // Pin synchronisation
  // ****************************************************************
  logic [SW-1:0]  pinRaw;
  logic [SW-1:0]  pinSync;
  logic [N-1:0]   sA, sB, sAn, sBn, sI, sIn, sXA, sXB, sFwd, sRev, sHome;
  logic           sAbortN, sResetN, sLock, sAbort, sReset;
  logic [`AFI_GPI_W-1:0] sGpi;
  logic [3*N-1:0] negRaw;
  logic [3*N-1:0] negSync;

  assign pinRaw = {encChanAPos, encChanBPos, encIndexPos, fwdLimit, revLimit, homeSwitch,
                   ~abortN, ~resetInN, lockout, genInput};
  assign negRaw = {encChanANeg, encChanBNeg, encIndexNeg};

  afi_sync #(.W(SW)) uSyncMain (
    .ref_clk (ref_clk),
    .rstn    (rstn),
    .pinIn   (pinRaw),
    .syncOut (pinSync)
  );
  afi_sync #(.W(3 * N)) uSyncNeg (
    .ref_clk (ref_clk),
    .rstn    (rstn),
    .pinIn   (negRaw),
    .syncOut (negSync)
  );
  afi_sync #(.W(2 * N)) uSyncAux (
    .ref_clk (ref_clk),
    .rstn    (rstn),
    .pinIn   ({auxEncFirstPos, auxEncSecondPos}),
    .syncOut ({sXA, sXB})
  );

  // Low-active pins enter inverted so the cleared sync flops do not fake an abort
  assign {sA, sB, sI, sFwd, sRev, sHome, sAbort, sReset, sLock, sGpi} = pinSync;
  assign sAbortN = ~sAbort;
  assign sResetN = ~sReset;
  assign {sAn, sBn, sIn} = negSync;

  // ****************************************************************
  // Registers
  // ****************************************************************
  logic [31:0]          ctrl_q, ctrl_d;
  logic [3*N-1:0]       mode_q, mode_d;
  logic [N-1:0]         arm_q, arm_d;
  logic [N-1:0]         latched_q, latched_d;
  afi_pkg::afi_pos_type latchVal_q [N], latchVal_d [N];
  afi_pkg::afi_pos_type homePos_q [N], homePos_d [N];
  afi_pkg::afi_home_type hs_q [N], hs_d [N];
  logic [N-1:0]         homeIdx_q, homeIdx_d;
  logic [N-1:0]         homePrev_q, homePrev_d;
  logic [31:0]          rdata_q, rdata_d;
  logic [N-1:0]         ampEn_q, ampEn_d;
  logic [N-1:0]         motEn_q, motEn_d;
  logic                 halt_q, halt_d;
  logic                 srst_q, srst_d;
  logic                 limReq_q, limReq_d;
  logic [`AFI_GPI_W-1:0] gpi_q, gpi_d;

  afi_pkg::afi_pos_type pos [N];
  afi_pkg::afi_pos_type aux [N];
  logic [N-1:0] fwdAct, revAct, homeAct, latchSrc, idxEdge;

  // ****************************************************************
  // Per-axis decoders and switch qualification
  // ****************************************************************
  for (genvar i = 0; i < N; i++) begin : gAxis
    afi_enc_if mainIf ();
    afi_enc_if auxIf ();
    // Negative legs only used when wired; floating legs are ignored
    assign mainIf.chanA    = diffUsed[i] ? (sA[i] & ~sAn[i]) : sA[i]; // R4
    assign mainIf.chanB    = diffUsed[i] ? (sB[i] & ~sBn[i]) : sB[i]; // R4
    assign mainIf.pulseDir = mode_q[i * `AFI_MODE_STRIDE + `AFI_MODE_PD]; // R3
    assign mainIf.enable   = 1'b1;
    assign auxIf.chanA     = sXA[i];
    assign auxIf.chanB     = sXB[i];
    assign auxIf.pulseDir  = 1'b0;
    assign auxIf.enable    = ~mode_q[i * `AFI_MODE_STRIDE + `AFI_MODE_STEP]; // R6
    afi_quad_dec uMain (.ref_clk(ref_clk), .rstn(rstn), .enc(mainIf));
    afi_quad_dec uAux  (.ref_clk(ref_clk), .rstn(rstn), .enc(auxIf));
    assign pos[i] = mainIf.count;
    assign aux[i] = auxIf.count;
    assign fwdAct[i]  = sFwd[i] ^ ctrl_q[`AFI_CTRL_LIMPOL]; // R12
    assign revAct[i]  = sRev[i] ^ ctrl_q[`AFI_CTRL_LIMPOL]; // R12
    assign homeAct[i] = sHome[i] ^ ctrl_q[`AFI_CTRL_HOMEPOL]; // R12
    assign idxEdge[i] = (diffUsed[i] ? (sI[i] & ~sIn[i]) : sI[i]) & ~homeIdx_q[i];
    // Axes 1-4 from inputs 1-4, axes 5-8 from inputs 9-12
    assign latchSrc[i] = (i < 4) ? sGpi[i] : sGpi[i + 4]; // R16
  end

  // ****************************************************************
  // Next state
  // ****************************************************************
  logic [3:0]  cmd;
  logic [2:0]  cmdAxis;
  logic        fwdDir;
  logic [2:0]  sel;

  always_comb begin
    cmd      = regWData[3:0];
    cmdAxis  = regWData[10:8];
    sel      = regAddr[`AFI_SEL_MSB:`AFI_SEL_LSB];
    fwdDir   = 1'b0;
    ctrl_d   = ctrl_q;
    mode_d   = mode_q;
    arm_d    = arm_q;
    latched_d = latched_q;
    latchVal_d = latchVal_q;
    homePos_d = homePos_q;
    hs_d     = hs_q;
    homeIdx_d = {sI & ~(diffUsed & sIn)};
    homePrev_d = homeAct;
    rdata_d  = 32'h0000_0000;
    limReq_d = 1'b0;
    halt_d   = ~sAbortN; // R7
    srst_d   = ~sResetN; // R8
    gpi_d    = sGpi; // R14
    if (regWrite) begin
      unique case (regAddr)
        `AFI_REG_CTRL:  ctrl_d = regWData;
        `AFI_REG_MODE:  mode_d = regWData[3*N-1:0];
        `AFI_REG_LARM: begin
          arm_d     = arm_q | regWData[N-1:0]; // R17
          latched_d = latched_q & ~regWData[N-1:0];
        end
        `AFI_REG_MOTION: begin
          unique case (cmd)
            `AFI_CMD_HOMING, `AFI_CMD_EDGE: hs_d[cmdAxis] = afi_pkg::HS_ARMED;
            `AFI_CMD_BEGIN: if (hs_q[cmdAxis] == afi_pkg::HS_ARMED) begin
              hs_d[cmdAxis] = afi_pkg::HS_SLEW; // R13
            end
            `AFI_CMD_STOP: hs_d[cmdAxis] = afi_pkg::HS_IDLE;
            default: hs_d[cmdAxis] = hs_q[cmdAxis];
          endcase
        end
        default: ctrl_d = ctrl_q;
      endcase
    end
    for (int i = 0; i < N; i++) begin
      fwdDir = mode_q[i * `AFI_MODE_STRIDE + `AFI_MODE_DIR];
      // Slewing stops on any home transition; index edge records home
      if (hs_q[i] == afi_pkg::HS_SLEW && homeAct[i] != homePrev_q[i]) begin
        hs_d[i] = afi_pkg::HS_STOP; // R13
      end
      if (hs_q[i] != afi_pkg::HS_IDLE && idxEdge[i]) begin
        homePos_d[i] = pos[i]; // R5
      end
      if (!sAbortN) begin
        hs_d[i] = afi_pkg::HS_IDLE; // R7
      end
      // Capture on latch input, then disarm until software re-arms
      if (arm_q[i] && ctrl_q[`AFI_CTRL_LATCHEN] && !latchSrc[i]) begin
        latchVal_d[i] = pos[i]; // R15
        arm_d[i]      = 1'b0; // R17
        latched_d[i]  = 1'b1; // R17
      end
      motEn_d[i] = sAbortN && !(fwdDir ? fwdAct[i] : revAct[i]) // R7 R10 R11
                   && hs_q[i] != afi_pkg::HS_STOP;
      ampEn_d[i] = !sLock && sAbortN; // R9
      if (fwdAct[i] || revAct[i]) begin
        limReq_d = 1'b1; // R10 R11
      end
    end
    if (regRead) begin
      unique case (regAddr[`AFI_BANK_MSB:`AFI_BANK_LSB])
        3'h0: begin
          unique case (regAddr)
            `AFI_REG_CTRL:   rdata_d = ctrl_q;
            `AFI_REG_MODE:   rdata_d = {8'h00, mode_q};
            `AFI_REG_STATUS: rdata_d = {8'h00, homeAct, fwdAct, revAct};
            `AFI_REG_GPI:    rdata_d = {16'h0000, sGpi}; // R14
            `AFI_REG_LARM:   rdata_d = {16'h0000, latched_q, arm_q};
            default:         rdata_d = 32'h0000_0000;
          endcase
        end
        3'h1:    rdata_d = pos[sel];
        3'h2:    rdata_d = aux[sel];
        3'h3:    rdata_d = latchVal_q[sel];
        3'h4:    rdata_d = homePos_q[sel];
        default: rdata_d = 32'h0000_0000;
      endcase
    end
    // Soft reset pin clears arms, latched flags and homing states; configuration and captured values stay
    if (!sResetN) begin
      arm_d     = '0; // R8
      latched_d = '0;
      for (int i = 0; i < N; i++) hs_d[i] = afi_pkg::HS_IDLE;
    end
  end

  // ****************************************************************
  // Registers update
  // ****************************************************************
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      ctrl_q     <= `AFI_CTRL_RESET;
      mode_q     <= '0;
      arm_q      <= '0;
      latched_q  <= '0;
      homeIdx_q  <= '0;
      homePrev_q <= '0;
      rdata_q    <= '0;
      ampEn_q    <= '0;
      motEn_q    <= '0;
      halt_q     <= 1'b0;
      srst_q     <= 1'b0;
      limReq_q   <= 1'b0;
      gpi_q      <= '0;
      for (int i = 0; i < N; i++) begin
        latchVal_q[i] <= '0;
        homePos_q[i]  <= '0;
        hs_q[i]       <= afi_pkg::HS_IDLE;
      end
    end else begin
      ctrl_q     <= ctrl_d;
      mode_q     <= mode_d;
      arm_q      <= arm_d;
      latched_q  <= latched_d;
      homeIdx_q  <= homeIdx_d;
      homePrev_q <= homePrev_d;
      rdata_q    <= rdata_d;
      ampEn_q    <= ampEn_d;
      motEn_q    <= motEn_d;
      halt_q     <= halt_d;
      srst_q     <= srst_d;
      limReq_q   <= limReq_d;
      gpi_q      <= gpi_d;
      latchVal_q <= latchVal_d;
      homePos_q  <= homePos_d;
      hs_q       <= hs_d;
    end
  end

  assign regRData        = rdata_q;
  assign ampEnable       = ampEn_q;
  assign motionEnable    = motEn_q;
  assign programHalt     = halt_q;
  assign softResetReq    = srst_q;
  assign limitHandlerReq = limReq_q;
  assign genInputState   = gpi_q;
endmodule : afi_axis_inputs

// File: rtl/afi_quad_dec.sv
// Quadrature or pulse/direction decoder with a position counter.
// Assumes synchronised channel inputs on ref_clk.
`timescale 1ns/1ps
`include "afi_regs.svh"
module afi_quad_dec (
  input  wire logic ref_clk,
  input  wire logic rstn,
  afi_enc_if.dec    enc
);
  logic                 prevA_q;
  logic                 prevB_q;
  logic                 prevA_d;
  logic                 prevB_d;
  afi_pkg::afi_pos_type count_q;
  afi_pkg::afi_pos_type count_d;
  logic                 step_q;
  logic                 step_d;

  always_comb begin
    prevA_d = enc.chanA;
    prevB_d = enc.chanB;
    count_d = count_q;
    step_d  = 1'b0;
    if (enc.enable) begin
      if (enc.pulseDir) begin
        // Rising edge of A counts; B level picks direction
        if (enc.chanA && !prevA_q) begin // R3
          count_d = enc.chanB ? count_q + 1'b1 : count_q - 1'b1; // R3
          step_d  = 1'b1;
        end
      end else begin
        // One clock per state: 125 MHz covers 22 M states/s with margin
        unique case ({prevA_q, prevB_q, enc.chanA, enc.chanB}) // R1 R2
          4'b0001, 4'b0111, 4'b1110, 4'b1000: begin
            count_d = count_q + 1'b1; // R1
            step_d  = 1'b1;
          end
          4'b0010, 4'b1011, 4'b1101, 4'b0100: begin
            count_d = count_q - 1'b1; // R1
            step_d  = 1'b1;
          end
          default: count_d = count_q;
        endcase
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      prevA_q <= 1'b0;
      prevB_q <= 1'b0;
      count_q <= '0;
      step_q  <= 1'b0;
    end else begin
      prevA_q <= prevA_d;
      prevB_q <= prevB_d;
      count_q <= count_d;
      step_q  <= step_d;
    end
  end

  assign enc.count = count_q;
  assign enc.step  = step_q;
endmodule : afi_quad_dec

// File: rtl/afi_sync.sv
// Two-flop synchroniser for a bus of pin inputs.
// Assumes asynchronous pins and one clock.
`timescale 1ns/1ps
module afi_sync #(
  parameter int W = 1
) (
  input  wire logic         ref_clk,
  input  wire logic         rstn,
  input  wire logic [W-1:0] pinIn,
  output logic      [W-1:0] syncOut
);
  logic [W-1:0] meta_q;
  logic [W-1:0] meta_d;
  logic [W-1:0] sync_q;
  logic [W-1:0] sync_d;

  always_comb begin
    meta_d = pinIn;
    sync_d = meta_q;
  end

  // First stage read only by the second
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign syncOut = sync_q;
endmodule : afi_sync

// File: test/afi_axis_inputs_props.sv
// Concurrent checks on the axis feedback input top ports.
// Assumes pins settle through two sync flops and one output register.
`timescale 1ns/1ps
`include "afi_regs.svh"
module afi_axis_inputs_props (
  input wire logic                   ref_clk,
  input wire logic                   rstn,
  input wire logic [`AFI_AXES-1:0]   fwdLimit,
  input wire logic [`AFI_AXES-1:0]   revLimit,
  input wire logic                   abortN,
  input wire logic                   resetInN,
  input wire logic                   lockout,
  input wire logic [`AFI_GPI_W-1:0]  genInput,
  input wire logic [`AFI_ADDR_W-1:0] regAddr,
  input wire logic [31:0]            regWData,
  input wire logic                   regWrite,
  input wire logic                   regRead,
  input wire logic [31:0]            regRData,
  input wire logic [`AFI_AXES-1:0]   ampEnable,
  input wire logic [`AFI_AXES-1:0]   motionEnable,
  input wire logic                   programHalt,
  input wire logic                   softResetReq,
  input wire logic                   limitHandlerReq,
  input wire logic [`AFI_GPI_W-1:0]  genInputState
);
  // ****
  // Shadow of CTRL and MODE
  // ****
  logic [2:0]  ctrl_q, ctrl_d;
  logic [23:0] mode_q, mode_d;
  logic [7:0]  fwdAct, revAct;
  always_comb begin
    ctrl_d = ctrl_q;
    mode_d = mode_q;
    if (regWrite && regAddr == `AFI_REG_CTRL) ctrl_d = regWData[2:0];
    if (regWrite && regAddr == `AFI_REG_MODE) mode_d = regWData[23:0];
  end
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      ctrl_q <= 3'h0;
      mode_q <= 24'h0;
    end else begin
      ctrl_q <= ctrl_d;
      mode_q <= mode_d;
    end
  end
  assign fwdAct = fwdLimit ^ {8{ctrl_q[0]}};
  assign revAct = revLimit ^ {8{ctrl_q[0]}};
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  sequence s_amp_held;
    ($stable({lockout, abortN}) && resetInN)[*3];
  endsequence
  sequence s_lim_held;
    (|(fwdAct | revAct))[*3];
  endsequence
  property p_amp;
    s_amp_held |=> ampEnable == {8{!$past(lockout) && $past(abortN)}};
  endproperty
  property p_abort;
    (!abortN)[*3] |=> programHalt && motionEnable == 8'h00;
  endproperty
  property p_soft;
    (!resetInN)[*3] |=> softResetReq;
  endproperty
  property p_lim_on;
    s_lim_held |=> limitHandlerReq;
  endproperty
  property p_lim_off;
    (!(|(fwdAct | revAct)))[*3] |=> !limitHandlerReq;
  endproperty
  property p_block;
    (mode_q[2] ? fwdAct[0] : revAct[0])[*3] |=> !motionEnable[0];
  endproperty
  property p_gpi;
    ($stable(genInput) && resetInN)[*3] |=> genInputState == $past(genInput);
  endproperty
  property p_ctrl_rd;
    regRead && regAddr == `AFI_REG_CTRL |=> regRData[2:0] == ctrl_q;
  endproperty
  property p_mode_rd;
    regRead && regAddr == `AFI_REG_MODE |=> regRData[23:0] == mode_q;
  endproperty
  property p_rd_idle;
    !regRead |=> regRData == 32'h0;
  endproperty
  a_amp: assert property (p_amp) else $error("amp enable wrong");
  a_abort: assert property (p_abort) else $error("abort not honoured");
  a_soft: assert property (p_soft) else $error("soft reset not raised");
  a_lim_on: assert property (p_lim_on) else $error("limit handler missing");
  a_lim_off: assert property (p_lim_off) else $error("limit handler spurious");
  a_block: assert property (p_block) else $error("limited motion allowed");
  a_gpi: assert property (p_gpi) else $error("input state wrong");
  a_ctrl_rd: assert property (p_ctrl_rd) else $error("polarity readback wrong");
  a_mode_rd: assert property (p_mode_rd) else $error("mode readback wrong");
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside slot");
endmodule : afi_axis_inputs_props
bind afi_axis_inputs afi_axis_inputs_props chk (.*);

// File: test/afi_enc_model.sv
// Behavioural incremental encoder: quadrature, pulse/direction, index.
// Assumes the bench routes its lines onto the axis pins it selects.
`timescale 1ns/1ps
module afi_enc_model (
  input  wire logic ref_clk,
  output logic      chanA,
  output logic      chanB,
  output logic      index
);
  // ****
  // Motion
  // ****
  initial begin
    chanA = 1'b0;
    chanB = 1'b0;
    index = 1'b0;
  end
  // Six clocks a state sits just inside the top quadrature rate
  task automatic wait6;
    repeat (6) @(posedge ref_clk);
  endtask : wait6
  task automatic quad(input int n);
    repeat ((n < 0) ? -n : n) begin
      wait6();
      if ((chanA == chanB) == (n > 0)) chanB <= ~chanB;
      else chanA <= ~chanA;
    end
  endtask : quad
  task automatic pulses(input logic dir, input int n);
    wait6();
    chanB <= dir;
    repeat (n) begin
      wait6();
      chanA <= 1'b1;
      wait6();
      chanA <= 1'b0;
    end
  endtask : pulses
  task automatic pulse_index;
    wait6();
    index <= 1'b1;
    wait6();
    index <= 1'b0;
  endtask : pulse_index
endmodule : afi_enc_model

// File: test/tb.sv
// Self-checking bench for the axis feedback input block.
// Assumes one encoder model, steered onto axes by select masks.
`timescale 1ns/1ps
`include "afi_regs.svh"
module tb;
  logic        ref_clk;
  logic        rstn = 1'b0, abortN = 1'b1, resetInN = 1'b1, lockout = 1'b0;
  logic [7:0]  sel = 8'h0, auxSel = 8'h0, diffUsed = 8'h0;
  logic [7:0]  fwdLimit = 8'h0, revLimit = 8'h0, homeSwitch = 8'h0;
  logic [15:0] genInput = 16'hFFFF;
  logic [7:0]  regAddr = 8'h0;
  logic [31:0] regWData = 32'h0;
  logic        regWrite = 1'b0, regRead = 1'b0;
  logic [31:0] regRData;
  logic [7:0]  ampEnable, motionEnable;
  logic        programHalt, softResetReq, limitHandlerReq, mA, mB, mI;
  logic [15:0] genInputState;
  int          err_count = 0, checks = 0;
  afi_enc_model enc (.ref_clk(ref_clk), .chanA(mA), .chanB(mB), .index(mI));
  afi_axis_inputs uut (.ref_clk(ref_clk), .rstn(rstn),
    .encChanAPos(sel & {8{mA}}), .encChanBPos(sel & {8{mB}}), .encIndexPos(sel & {8{mI}}),
    .encChanANeg(sel & diffUsed & {8{~mA}}), .encChanBNeg(sel & diffUsed & {8{~mB}}),
    .encIndexNeg(sel & diffUsed & {8{~mI}}), .diffUsed(diffUsed),
    .auxEncFirstPos(auxSel & {8{mA}}), .auxEncSecondPos(auxSel & {8{mB}}),
    .fwdLimit(fwdLimit), .revLimit(revLimit), .homeSwitch(homeSwitch), .abortN(abortN),
    .resetInN(resetInN), .lockout(lockout), .genInput(genInput), .regAddr(regAddr),
    .regWData(regWData), .regWrite(regWrite), .regRead(regRead), .regRData(regRData),
    .ampEnable(ampEnable), .motionEnable(motionEnable), .programHalt(programHalt),
    .softResetReq(softResetReq), .limitHandlerReq(limitHandlerReq),
    .genInputState(genInputState));
  // ****
  // Bus and check helpers
  // ****
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] e);
    checks++;
    if (got !== e) begin
      err_count++;
      $display("unexpected at %0t: got %h exp %h", $time, got, e);
    end
  endtask : chk
  // Four edges cover the two sync flops and the output register
  task automatic settle;
    repeat (4) @(posedge ref_clk);
    #1;
  endtask : settle
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    regAddr <= a;
    regWData <= d;
    regWrite <= 1'b1;
    @(posedge ref_clk);
    regWrite <= 1'b0;
  endtask : wr
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    @(posedge ref_clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge ref_clk);
    regRead <= 1'b0;
    #1;
    chk(regRData, e);
  endtask : rdc
  // ****
  // Scenarios
  // ****
  task automatic t_quad;
    @(posedge ref_clk);
    sel <= 8'h09;
    diffUsed <= 8'h01;
    enc.quad(4);
    settle();
    rdc(`AFI_REG_POS, 32'h4);
    rdc(`AFI_REG_POS + 8'h0C, 32'h4);
    enc.quad(-8);
    settle();
    rdc(`AFI_REG_POS, 32'hFFFF_FFFC);
    rdc(`AFI_REG_POS + 8'h0C, 32'hFFFF_FFFC);
  endtask : t_quad
  task automatic t_pd_aux;
    wr(`AFI_REG_MODE, 32'h8);
    @(posedge ref_clk);
    sel <= 8'h2;
    enc.pulses(1'b1, 3);
    enc.pulses(1'b0, 1);
    settle();
    rdc(`AFI_REG_POS + 8'h4, 32'h2);
    wr(`AFI_REG_MODE, 32'h8_0000);
    @(posedge ref_clk);
    sel <= 8'h0;
    auxSel <= 8'hC0;
    enc.quad(4);
    settle();
    rdc(`AFI_REG_AUX + 8'h18, 32'h0);
    rdc(`AFI_REG_AUX + 8'h1C, 32'h4);
    @(posedge ref_clk);
    auxSel <= 8'h0;
  endtask : t_pd_aux
  task automatic t_abort_lock;
    @(posedge ref_clk);
    abortN <= 1'b0;
    settle();
    chk(32'(programHalt), 32'h1);
    chk(32'(motionEnable), 32'h0);
    @(posedge ref_clk);
    abortN <= 1'b1;
    lockout <= 1'b1;
    settle();
    chk(32'(ampEnable), 32'h0);
    chk(32'(motionEnable), 32'hFF);
    @(posedge ref_clk);
    lockout <= 1'b0;
    settle();
    chk(32'(ampEnable), 32'hFF);
  endtask : t_abort_lock
  task automatic t_limits;
    wr(`AFI_REG_MODE, 32'h4);
    @(posedge ref_clk);
    fwdLimit <= 8'h1;
    settle();
    chk(32'(motionEnable), 32'hFE);
    chk(32'(limitHandlerReq), 32'h1);
    rdc(`AFI_REG_STATUS, 32'h100);
    wr(`AFI_REG_MODE, 32'h0);
    settle();
    chk(32'(motionEnable), 32'hFF);
    @(posedge ref_clk);
    fwdLimit <= 8'h0;
    revLimit <= 8'h1;
    settle();
    chk(32'(motionEnable), 32'hFE);
    wr(`AFI_REG_CTRL, 32'h3);
    @(posedge ref_clk);
    fwdLimit <= 8'hFF;
    revLimit <= 8'hFE;
    settle();
    rdc(`AFI_REG_STATUS, 32'hFF_0001);
    chk(32'(motionEnable), 32'hFE);
    @(posedge ref_clk);
    revLimit <= 8'hFF;
    settle();
    chk(32'(limitHandlerReq), 32'h0);
    wr(`AFI_REG_CTRL, 32'h0);
    @(posedge ref_clk);
    fwdLimit <= 8'h0;
    revLimit <= 8'h0;
  endtask : t_limits
  task automatic t_home;
    @(posedge ref_clk);
    sel <= 8'h01;
    for (int c = `AFI_CMD_HOMING; c <= `AFI_CMD_EDGE; c++) begin
      wr(`AFI_REG_MOTION, 32'(c));
      wr(`AFI_REG_MOTION, 32'(`AFI_CMD_BEGIN));
      settle();
      chk(32'(motionEnable), 32'hFF);
      enc.pulse_index();
      settle();
      rdc(`AFI_REG_HOME, 32'hFFFF_FFFC);
      @(posedge ref_clk);
      homeSwitch <= ~homeSwitch;
      settle();
      chk(32'(motionEnable), 32'hFE);
      @(posedge ref_clk);
      abortN <= 1'b0;
      settle();
      @(posedge ref_clk);
      abortN <= 1'b1;
      settle();
    end
  endtask : t_home
  task automatic t_gpi;
    @(posedge ref_clk);
    genInput <= 16'h5AC3;
    settle();
    chk(32'(genInputState), 32'h5AC3);
    rdc(`AFI_REG_GPI, 32'h5AC3);
    rdc(8'hA0, 32'h0);
    @(posedge ref_clk);
    genInput <= 16'hFFFF;
  endtask : t_gpi
  task automatic t_latch;
    wr(`AFI_REG_CTRL, 32'h4);
    @(posedge ref_clk);
    sel <= 8'h11;
    enc.quad(4);
    settle();
    wr(`AFI_REG_LARM, 32'h11);
    rdc(`AFI_REG_LARM, 32'h11);
    @(posedge ref_clk);
    genInput <= 16'hFFEF;
    settle();
    rdc(`AFI_REG_LARM, 32'h11);
    @(posedge ref_clk);
    genInput <= 16'hFEFE;
    settle();
    rdc(`AFI_REG_LARM, 32'h1100);
    rdc(`AFI_REG_LATCH, 32'h0);
    rdc(`AFI_REG_LATCH + 8'h10, 32'h4);
    enc.quad(4);
    settle();
    rdc(`AFI_REG_LATCH, 32'h0);
    wr(`AFI_REG_LARM, 32'h1);
    settle();
    rdc(`AFI_REG_LATCH, 32'h4);
    rdc(`AFI_REG_LARM, 32'h1100);
  endtask : t_latch
  task automatic t_soft;
    @(posedge ref_clk);
    resetInN <= 1'b0;
    settle();
    chk(32'(softResetReq), 32'h1);
    @(posedge ref_clk);
    resetInN <= 1'b1;
    settle();
    rdc(`AFI_REG_CTRL, 32'h4);
    rdc(`AFI_REG_LARM, 32'h0);
  endtask : t_soft
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : wrap_up
  // Whole run is a few hundred cycles; the limit leaves wide margin
  initial begin
    repeat (20000) @(posedge ref_clk);
    err_count++;
    wrap_up();
  end
  initial begin
    repeat (10) @(posedge ref_clk);
    rstn <= 1'b1;
    t_quad();
    t_pd_aux();
    t_abort_lock();
    t_limits();
    t_home();
    t_gpi();
    t_latch();
    t_soft();
    wrap_up();
  end
endmodule : tb
